// ---- common/exec_pkg.sv ----
package exec_pkg;

  // Phases of one instruction cycle.
  localparam logic [1:0] PH_DECODE  = 2'h0;
  localparam logic [1:0] PH_READ    = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE   = 2'h3;

  // Opcode patterns on the upper bits of the instruction word.
  localparam logic [7:0] OP_ADD_LITERAL = 8'h0f;
  localparam logic [5:0] OP_ADD_REGISTER = 6'h09;
  localparam logic [3:0] OP_BIT_INVERT  = 4'h7;
  localparam logic [7:0] OP_BRANCH_WRAP = 8'he4;
  localparam logic [7:0] OP_BRANCH_ZERO = 8'he0;
  localparam logic [6:0] OP_CALL_FIRST  = 7'h76;
  localparam logic [3:0] OP_CALL_SECOND = 4'hf;

  // Flag positions in the flags register.
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  // Reset values and counter steps.
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [20:0] PC_RESET    = 21'h000000;
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam logic [20:0] CALL_RETURN_STEP = 21'h000004;

  // Data-side request toward the register file.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } data_req_t;

  // Result of the adder.
  typedef struct packed {
    logic [7:0] sum;
    logic [7:0] flags;
  } add_res_t;

endpackage

// ---- rtl/add_flags.sv ----
`timescale 1ns/10ps
// Eight-bit adder that also forms the arithmetic flags.
module add_flags
  import exec_pkg::*;
(
  input  wire logic [7:0] a,        // First operand.
  input  wire logic [7:0] b,        // Second operand.
  input  wire logic [7:0] flags_in, // Current flags; upper bits kept.
  output add_res_t        res       // Sum and new flags.
);

  logic [8:0] full;
  logic [4:0] low;

  // The half carry comes from the low nibble sum alone.
  always_comb begin
    full = {1'b0, a} + {1'b0, b};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    res.sum = full[7:0];
    res.flags = flags_in;
    res.flags[FLAG_C]  = full[8];
    res.flags[FLAG_DC] = low[4];
    res.flags[FLAG_Z]  = (full[7:0] == 8'h00);
    res.flags[FLAG_OV] = (a[7] == b[7]) && (full[7] != a[7]);
    res.flags[FLAG_N]  = full[7];
  end

endmodule

// ---- rtl/instr_exec_add_branch_call.sv ----
`timescale 1ns/10ps
// What this block does
// - The add-literal opcode adds the low-byte literal to the accumulator, keeps the sum there and sets N, OV, C, DC, Z.
// - The add-register opcode adds the accumulator to the file register and stores in the accumulator when d is 0.
// - With the destination bit at 1 the result goes back into the addressed file register.
// - Bank-select bit 0 addresses the fixed access bank, bit 1 uses the bank selector register.
// - The bit-invert opcode flips one bit of a data location in one cycle and leaves flags alone.
// - The branch on signed wrap is taken only when the signed-wrap flag is 1, flags unchanged.
// - The branch on zero is taken only when the zero flag is 1, flags unchanged.
// - A taken branch loads the incremented counter plus twice the signed offset, offset -128 to 127.
// - A branch takes one cycle when not taken and two when taken, the second a no-operation.
// - The call pushes the counter plus 4 onto the return stack before loading the target.
// - With the fast bit at 1 the call copies accumulator, flags and bank selector into shadows, else shadows stay.
// - The call is two words carrying a 20-bit target that is loaded into counter bits 20:1.
// - The call takes two cycles, the second a no-operation; the second word is read in the write phase of the first.
module instr_exec_add_branch_call
  import exec_pkg::*;
(
  input  wire logic        clk,           // Core clock.
  input  wire logic        rst,           // Synchronous reset, active high.
  input  wire logic [15:0] instr,         // Instruction word at the fetch address.
  input  wire logic [7:0]  data_rdata,    // Read data from the register file.
  output logic [20:0]      fetch_addr,    // Program counter, byte address.
  output data_req_t        data_req,      // Register file request.
  output logic             stack_push,    // One-cycle push strobe.
  output logic [20:0]      stack_top,     // Return address being pushed.
  output logic [7:0]       acc,           // Accumulator.
  output logic [7:0]       flags,         // Flags register.
  output logic [3:0]       bank_selector, // Bank selector register.
  output logic [7:0]       shadow_accumulator,   // Shadow of the accumulator.
  output logic [7:0]       shadow_flags,         // Shadow of the flags.
  output logic [3:0]       shadow_bank_selector, // Shadow of the bank selector.
  output logic [1:0]       phase          // Current phase of the cycle.
);

  logic [1:0]  phase_q;
  logic [20:0] pc_q;
  logic [15:0] ir_q;
  logic [7:0]  opnd_q;
  logic [7:0]  acc_q;
  logic [7:0]  flags_q;
  logic        noop_q;
  logic        push_q;
  logic [20:0] push_addr_q;
  logic [7:0]  sacc_q;
  logic [7:0]  sflags_q;
  logic [11:0] addr_q;
  logic [3:0]  bsr_q;
  logic [3:0]  sbsr_q;
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  wdata_q;
  add_res_t    add_res;

  // Bank-qualified data address. The access bank splits on bit 7 into the low and the top half.
  function automatic logic [11:0] data_address(input logic [15:0] w);
    if (w[8]) begin
      return {bsr_q, w[7:0]};
    end
    return {{4{w[7]}}, w[7:0]};
  endfunction

  wire is_addl = (ir_q[15:8] == OP_ADD_LITERAL);
  wire is_addr = (ir_q[15:10] == OP_ADD_REGISTER);
  wire is_btg  = (ir_q[15:12] == OP_BIT_INVERT);
  wire is_bov  = (ir_q[15:8] == OP_BRANCH_WRAP);
  wire is_bz   = (ir_q[15:8] == OP_BRANCH_ZERO);
  wire is_call = (ir_q[15:9] == OP_CALL_FIRST);
  wire taken   = (is_bov && flags_q[FLAG_OV]) || (is_bz && flags_q[FLAG_Z]);
  wire [20:0] branch_target = pc_q + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};

  // Adder operand is the literal or the register read.
  add_flags u_add (
    .a        (acc_q),
    .b        (is_addl ? ir_q[7:0] : opnd_q),
    .flags_in (flags_q),
    .res      (add_res)
  );

  // Four-phase sequencer.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= PH_DECODE;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Instruction latch and no-operation tracking. A second-cycle slot never decodes.
  always_ff @(posedge clk) begin
    if (rst) begin
      ir_q   <= 16'h0000;
      noop_q <= 1'b0;
    end else if (phase_q == PH_DECODE) begin
      ir_q <= noop_q ? 16'h0000 : instr;
    end else if (phase_q == PH_WRITE) begin
      noop_q <= !noop_q && (taken || is_call);
    end
  end

  // Program counter. The call target is latched from bits 11:0 of the second word and the low byte of the first.
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= PC_RESET;
    end else if (phase_q == PH_DECODE && !noop_q) begin
      pc_q <= pc_q + PC_STEP;
    end else if (phase_q == PH_WRITE && !noop_q && taken) begin
      pc_q <= branch_target;
    end else if (phase_q == PH_WRITE && !noop_q && is_call) begin
      pc_q <= {instr[11:0], ir_q[7:0], 1'b0};
    end
  end

  // Return stack push, in process phase before the counter is reloaded.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_q      <= 1'b0;
      push_addr_q <= PC_RESET;
    end else begin
      push_q <= (phase_q == PH_READ) && !noop_q && is_call;
      if ((phase_q == PH_READ) && !noop_q && is_call) begin
        push_addr_q <= pc_q - PC_STEP + CALL_RETURN_STEP;
      end
    end
  end

  // Shadow save on a fast call only.
  always_ff @(posedge clk) begin
    if (rst) begin
      sacc_q   <= ACC_RESET;
      sflags_q <= FLAGS_RESET;
      sbsr_q   <= 4'h0;
    end else if (phase_q == PH_PROCESS && !noop_q && is_call && ir_q[8]) begin
      sacc_q   <= acc_q;
      sflags_q <= flags_q;
      sbsr_q   <= bsr_q;
    end
  end

  // Operand read strobe and capture. Data arrives one edge after the strobe.
  // The address is latched with the word, so it stands from the read strobe until the
  // write strobe of the next cycle has been taken, and the port comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q   <= 1'b0;
      opnd_q <= 8'h00;
      addr_q <= 12'h000;
    end else begin
      if (phase_q == PH_DECODE && !noop_q) begin
        addr_q <= data_address(instr);
      end
      rd_q <= (phase_q == PH_DECODE) && !noop_q && (instr[15:10] == OP_ADD_REGISTER || instr[15:12] == OP_BIT_INVERT);
      if (phase_q == PH_PROCESS) begin
        opnd_q <= data_rdata;
      end
    end
  end

  // Accumulator, flags and register writeback in the write phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q   <= ACC_RESET;
      flags_q <= FLAGS_RESET;
      wr_q    <= 1'b0;
      wdata_q <= 8'h00;
      bsr_q   <= 4'h0;
    end else begin
      wr_q <= 1'b0;
      if (phase_q == PH_WRITE && !noop_q) begin
        if (is_addl || (is_addr && !ir_q[9])) begin
          acc_q   <= add_res.sum;
          flags_q <= add_res.flags;
        end else if (is_addr) begin
          flags_q <= add_res.flags;
          wr_q    <= 1'b1;
          wdata_q <= add_res.sum;
        end else if (is_btg) begin
          wr_q    <= 1'b1;
          wdata_q <= opnd_q ^ (8'h01 << ir_q[11:9]);
        end
      end
    end
  end

  assign fetch_addr           = pc_q;
  assign data_req.rd          = rd_q;
  assign data_req.wr          = wr_q;
  assign data_req.addr        = addr_q;
  assign data_req.wdata       = wdata_q;
  assign stack_push           = push_q;
  assign stack_top            = push_addr_q;
  assign acc                  = acc_q;
  assign flags                = flags_q;
  assign bank_selector        = bsr_q;
  assign shadow_accumulator   = sacc_q;
  assign shadow_flags         = sflags_q;
  assign shadow_bank_selector = sbsr_q;
  assign phase                = phase_q;

  // Checks.
  property p_phase_step;
    @(posedge clk) disable iff (rst) 1'b1 |=> phase_q == $past(phase_q) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");

  property p_branch_noop;
    @(posedge clk) disable iff (rst) (phase_q == PH_WRITE && !noop_q && taken) |=> noop_q;
  endproperty
  a_branch_noop: assert property (p_branch_noop) else $error("taken branch lacks noop");

  property p_untaken;
    @(posedge clk) disable iff (rst) (phase_q == PH_WRITE && !noop_q && (is_bov || is_bz) && !taken) |=> !noop_q;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch stalled");

  property p_flags_keep;
    @(posedge clk) disable iff (rst) (phase_q == PH_WRITE && (is_btg || is_bov || is_bz || is_call)) |=> $stable(flags_q);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("flags changed");

  property p_push_addr;
    @(posedge clk) disable iff (rst) push_q |-> push_addr_q == pc_q + PC_STEP;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("bad return address");

  property p_call_noop;
    @(posedge clk) disable iff (rst) (phase_q == PH_WRITE && !noop_q && is_call) |=> noop_q ##4 !noop_q;
  endproperty
  a_call_noop: assert property (p_call_noop) else $error("call not two cycles");

  property p_shadow_keep;
    @(posedge clk) disable iff (rst) !(phase_q == PH_PROCESS && is_call && ir_q[8] && !noop_q) |=> $stable(sacc_q);
  endproperty
  a_shadow_keep: assert property (p_shadow_keep) else $error("shadow changed");

  property p_acc_dest;
    @(posedge clk) disable iff (rst) (phase_q == PH_WRITE && !noop_q && is_addr && ir_q[9]) |=> wr_q && $stable(acc_q);
  endproperty
  a_acc_dest: assert property (p_acc_dest) else $error("destination wrong");

  c_call:   cover property (@(posedge clk) disable iff (rst) push_q);
  c_branch: cover property (@(posedge clk) disable iff (rst) phase_q == PH_WRITE && taken && !noop_q);
  c_write:  cover property (@(posedge clk) disable iff (rst) wr_q);

endmodule

// ---- testbench/prog_data_model.sv ----
`timescale 1ns/10ps
// Program memory and data register file on the far side of the decoder.
module prog_data_model
  import exec_pkg::*;
(
  input  wire logic        clk,        // Core clock.
  input  wire logic [20:0] fetch_addr, // Byte address of the fetched word.
  input  wire data_req_t   data_req,   // Register file request.
  output logic [15:0]      instr,      // Word at the fetch address.
  output logic [7:0]       data_rdata  // Register file read data.
);
  logic [15:0] rom [0:255];
  logic [7:0]  ram [0:4095];

  // Unloaded words read as zero, an undefined opcode that must act as no operation.
  initial begin
    for (int i = 0; i < 256; i++) rom[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) ram[i] = 8'h00;
  end

  // Reads are combinational because the decoder samples data at the end of the process phase and the word at the end of the decode and write phases.
  assign instr = rom[fetch_addr[8:1]];
  assign data_rdata = ram[data_req.addr];

  // Writes land on the clock edge that ends the write strobe.
  always @(posedge clk) begin
    if (data_req.wr === 1'b1) ram[data_req.addr] <= data_req.wdata;
  end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb
  import exec_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [15:0] instr;
  logic [7:0]  data_rdata;
  logic [20:0] fetch_addr;
  logic [20:0] stack_top;
  data_req_t   data_req;
  logic        stack_push;
  logic [7:0]  acc;
  logic [7:0]  flags;
  logic [3:0]  bank_selector;
  logic [7:0]  shadow_accumulator;
  logic [7:0]  shadow_flags;
  logic [3:0]  shadow_bank_selector;
  logic [1:0]  phase;
  int          failures;
  int          compares;
  int          pushes;

  instr_exec_add_branch_call dut (.clk, .rst, .instr, .data_rdata, .fetch_addr, .data_req, .stack_push,
    .stack_top, .acc, .flags, .bank_selector, .shadow_accumulator, .shadow_flags, .shadow_bank_selector, .phase);
  prog_data_model m (.clk, .fetch_addr, .data_req, .instr, .data_rdata);

  // A free-running clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Push strobes are counted so a doubled or missing push shows up.
  always @(posedge clk) begin
    if (stack_push === 1'b1) pushes++;
  end

  task automatic chk_val(input logic [20:0] got, input logic [20:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk_val({13'h0, got}, {13'h0, exp});
  endtask

  task automatic chk_cyc(input int got, input int exp);
    compares++;
    if (got != exp) begin
      failures++;
      $display("mismatch at %0t: took %0d cycles expected %0d", $time, got, exp);
    end
  endtask

  // Counts clocks until the counter reaches the given fetch address; the bound stops a stuck counter.
  task automatic step(input logic [20:0] pc, input int cyc);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fetch_addr !== pc && n < 40);
    chk_cyc(n, cyc);
    chk8({6'h0, phase}, {6'h0, PH_READ});
  endtask

  task automatic t_reset();
    rst = 1'b1;
    // The program goes in after the first edge, so the model's clearing at time zero cannot wipe it.
    @(negedge clk);
    m.rom[8'h00] = 16'h0f15;
    m.rom[8'h01] = 16'h2420;
    m.rom[8'h02] = 16'h2621;
    m.rom[8'h03] = 16'h7685;
    m.rom[8'h04] = 16'h7985;
    m.rom[8'h05] = 16'he405;
    m.rom[8'h06] = 16'he003;
    m.rom[8'h07] = 16'h0f01;
    m.rom[8'h08] = 16'h0f01;
    m.rom[8'h09] = 16'h0f01;
    m.rom[8'h0a] = 16'hed40;
    m.rom[8'h0b] = 16'hf000;
    m.rom[8'h0c] = 16'h0f01;
    m.rom[8'h0d] = 16'hec50;
    m.rom[8'h0e] = 16'hf000;
    m.rom[8'h40] = 16'h0f80;
    m.rom[8'h41] = 16'he4ca;
    m.ram[12'h020] = 8'hc2;
    m.ram[12'h021] = 8'h29;
    m.ram[12'hf85] = 8'h75;
    m.ram[12'h085] = 8'h75;
    repeat (5) @(negedge clk);
    chk_val(fetch_addr, PC_RESET);
    chk8(acc, ACC_RESET);
    chk8(flags, FLAGS_RESET);
    rst = 1'b0;
  endtask

  task automatic t_add();
    step(21'h2, 1);
    step(21'h4, 4);
    chk8(acc, 8'h15);
    step(21'h6, 4);
    chk8(acc, 8'hd7);
    chk8(flags, 8'h10);
    step(21'h8, 4);
    chk8(acc, 8'hd7);
    chk8(flags, 8'h07);
    chk8(m.ram[12'h021], 8'h00);
  endtask

  task automatic t_invert();
    step(21'ha, 4);
    step(21'hc, 4);
    chk8(m.ram[12'hf85], 8'h7d);
    chk8(m.ram[12'h085], 8'h65);
    chk8({4'h0, bank_selector}, 8'h00);
    chk8(flags, 8'h07);
  endtask

  // A wrap branch not taken, then a zero branch taken over three adds.
  task automatic t_branch();
    step(21'he, 4);
    step(21'h16, 8);
    chk8(acc, 8'hd7);
    chk8(flags, 8'h07);
  endtask

  task automatic t_call_fast();
    step(21'h82, 8);
    chk_val(stack_top, 21'h18);
    chk_cyc(pushes, 1);
    chk8(shadow_accumulator, 8'hd7);
    chk8(shadow_flags, 8'h07);
    chk8({4'h0, shadow_bank_selector}, 8'h00);
  endtask

  // The add sets the signed-wrap flag, then a backward branch is taken.
  task automatic t_wrap_back();
    step(21'h84, 4);
    chk8(acc, 8'h57);
    chk8(flags, 8'h09);
    step(21'h1a, 8);
    step(21'h1c, 4);
    chk8(acc, 8'h58);
    chk8(flags, 8'h00);
  endtask

  task automatic t_call_plain();
    step(21'ha2, 8);
    chk_val(stack_top, 21'h1e);
    chk_cyc(pushes, 2);
    chk8(shadow_accumulator, 8'hd7);
    chk8(shadow_flags, 8'h07);
    step(21'ha4, 4);
    chk8(acc, 8'h58);
  endtask

  task automatic print_verdict();
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence; the program in memory runs straight through all scenarios.
  initial begin
    rst = 1'b1;
    t_reset();
    t_add();
    t_invert();
    t_branch();
    t_call_fast();
    t_wrap_back();
    t_call_plain();
    print_verdict();
  end

  // The run needs about 75 cycles; a hang is cut short well beyond that.
  initial begin
    #10000;
    failures++;
    print_verdict();
  end
endmodule
